// ==== verilog/uhr_top.v ====
// Register bank and address decoder of the host controller behind the processor bus.
// What this block does
// - Every register is a 32-bit word; no narrower access on a 32-bit bus.
// - On a 16-bit bus two halves are written before the word is stored; a read takes the word on the lower half.
// - Offsets 000h to 1FFh decode as the operational register group.
// - Host and OTG configuration and interrupt registers lie only in 300h to 3FFh.
// - Offsets 200h to 2FFh go to the peripheral controller, not this bank.
// - Seventeen address lines; 15 or 14 of them span 64 kB by bus width.
// - Two extra address lines select a bank for virtual segmentation.
// - No byte lane address bit; 8-bit accesses are not supported.
// - Capability length reads constant 20h in bits 7 to 0.
// - Interface version reads constant BCD 0100h in its 16 bits.
// - Reset comes only from the external active-low I_RST_N input.
`include "uhr_consts.vh"
module uhr_top (
    input  wire        I_CLK,
    input  wire        I_RST_N,
    input  wire        I_CS_N,
    input  wire        I_RD_N,
    input  wire        I_WR_N,
    input  wire [17:1] I_ADDR,
    input  wire [31:0] I_DATA,
    input  wire        I_BUS16,
    input  wire [31:0] I_PERIPH_RDATA,
    output wire [31:0] O_DATA,
    output wire        O_DATA_OE_N,
    output wire [1:0]  O_BANK,
    output wire        O_PERIPH_SEL,
    output wire        O_PERIPH_RD,
    output wire        O_PERIPH_WR,
    output wire [7:0]  O_PERIPH_OFS,
    output wire [31:0] O_PERIPH_WDATA,
    output wire [31:0] O_HOST_CMD,
    output wire [31:0] O_HW_MODE
);
    // Slot index of each storing register; bit 6 marks a listed offset.
    function [6:0] slot_of;
        input [9:0] ofs;
        begin
            case (ofs)
                `UHR_OFS_HCMD:    slot_of = 7'h40;
                `UHR_OFS_HSTS:    slot_of = 7'h41;
                `UHR_OFS_HIEN:    slot_of = 7'h42;
                `UHR_OFS_FRIDX:   slot_of = 7'h43;
                `UHR_OFS_CFGFLG:  slot_of = 7'h44;
                `UHR_OFS_PORT1:   slot_of = 7'h45;
                `UHR_OFS_ISODONE: slot_of = 7'h46;
                `UHR_OFS_ISOSKIP: slot_of = 7'h47;
                `UHR_OFS_ISOLAST: slot_of = 7'h48;
                `UHR_OFS_INTDONE: slot_of = 7'h49;
                `UHR_OFS_INTSKIP: slot_of = 7'h4A;
                `UHR_OFS_INTLAST: slot_of = 7'h4B;
                `UHR_OFS_ASYDONE: slot_of = 7'h4C;
                `UHR_OFS_ASYSKIP: slot_of = 7'h4D;
                `UHR_OFS_ASYLAST: slot_of = 7'h4E;
                `UHR_OFS_HWMODE:  slot_of = 7'h4F;
                `UHR_OFS_SCRATCH: slot_of = 7'h50;
                `UHR_OFS_SWRST:   slot_of = 7'h51;
                `UHR_OFS_IRQFLG:  slot_of = 7'h52;
                `UHR_OFS_IRQFEN:  slot_of = 7'h53;
                `UHR_OFS_ISOOR:   slot_of = 7'h54;
                `UHR_OFS_INTOR:   slot_of = 7'h55;
                `UHR_OFS_ASYOR:   slot_of = 7'h56;
                `UHR_OFS_ISOAND:  slot_of = 7'h57;
                `UHR_OFS_INTAND:  slot_of = 7'h58;
                `UHR_OFS_ASYAND:  slot_of = 7'h59;
                `UHR_OFS_DMACFG:  slot_of = 7'h5A;
                `UHR_OFS_BUFSTS:  slot_of = 7'h5B;
                `UHR_OFS_ASYTMO:  slot_of = 7'h5C;
                `UHR_OFS_MEMSET:  slot_of = 7'h5D;
                `UHR_OFS_EDGECNT: slot_of = 7'h5E;
                `UHR_OFS_DMASTA:  slot_of = 7'h5F;
                `UHR_OFS_PWRDN:   slot_of = 7'h60;
                default:          slot_of = 7'h00;
            endcase
        end
    endfunction

    // Reset value of each storing slot.
    function [31:0] rst_of;
        input [5:0] s;
        begin
            case (s)
                6'h00:   rst_of = `UHR_RST_HCMD;
                6'h05:   rst_of = `UHR_RST_PORT1;
                6'h07:   rst_of = `UHR_RST_SKIP;
                6'h0A:   rst_of = `UHR_RST_SKIP;
                6'h0D:   rst_of = `UHR_RST_SKIP;
                6'h0F:   rst_of = `UHR_RST_HWMODE;
                6'h1E:   rst_of = `UHR_RST_EDGECNT;
                6'h20:   rst_of = `UHR_RST_PWRDN;
                default: rst_of = `UHR_RST_ZERO;
            endcase
        end
    endfunction

    // Peripheral controller range test on a byte offset.
    function is_periph;
        input [15:0] ofs;
        begin
            is_periph = (ofs[15:10] == 6'h00) && (ofs[9:8] == `UHR_PER_REGION);
        end
    endfunction

    wire [52:0] sy;
    wire        bus16;
    wire        cs;
    wire        rd;
    wire        wr;
    wire [17:1] addr;
    wire [31:0] wd;
    wire        rd_act;
    wire        wr_act;
    wire        rd_go;
    wire        wr_go;
    wire [15:0] rofs;
    wire [15:0] wofs;
    wire        hi;
    wire [31:0] pair_rdata;
    wire        word_rd;
    wire        word_wr;
    wire [31:0] word_wdata;
    wire [6:0]  wslot;
    wire        w_host;
    wire        w_periph;
    wire        r_periph;

    reg         rd_act_q;
    reg         wr_act_q;
    reg  [17:1] waddr_q;
    reg  [31:0] wd_q;
    reg  [31:0] data_q;
    reg         oe_n_q;
    reg  [1:0]  bank_q;
    reg         psel_q;
    reg         pwr_q;
    reg  [7:0]  pofs_q;
    reg  [31:0] pwdata_q;
    reg  [31:0] regs_q [0:`UHR_NUM_SLOTS-1];
    reg  [31:0] rword;
    reg  [6:0]  rslot;
    integer     i;

    // Strobes, address, data and the width strap all cross in through two flops.
    uhr_pin_sync #(
        .W (53)
    ) u_sync (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_d     ({I_BUS16, I_CS_N, I_RD_N, I_WR_N, I_ADDR, I_DATA}),
        .o_q     (sy)
    );

    assign bus16  = sy[52];
    assign cs     = ~sy[51];
    assign rd     = ~sy[50];
    assign wr     = ~sy[49];
    assign addr   = sy[48:32];
    assign wd     = sy[31:0];
    assign rd_act = cs & rd;
    assign wr_act = cs & wr;

    // A read is taken as its strobe opens; a write as its strobe closes.
    assign rd_go = rd_act & ~rd_act_q;
    assign wr_go = wr_act_q & ~wr_act;

    // Byte offsets carry no lane bit; the upper two lines pick the bank.
    assign rofs = {addr[15:1], 1'b0};
    assign wofs = {waddr_q[15:1], 1'b0};
    assign hi   = rd_go ? addr[1] : waddr_q[1];

    uhr_half_pair u_pair (
        .i_clk        (I_CLK),
        .i_rst_n      (I_RST_N),
        .i_bus16      (bus16),
        .i_rd_go      (rd_go),
        .i_wr_go      (wr_go),
        .i_hi         (hi),
        .i_wdata      (wd_q),
        .i_rword      (rword),
        .o_rdata      (pair_rdata),
        .o_word_rd    (word_rd),
        .o_word_wr    (word_wr),
        .o_word_wdata (word_wdata)
    );

    // Word offsets ignore line 1 so a 32-bit bus always sees whole words.
    assign wslot    = slot_of({wofs[9:2], 2'b00});
    assign w_host   = (wofs[15:10] == 6'h00) & ~is_periph(wofs);
    assign w_periph = is_periph(wofs);
    assign r_periph = is_periph(rofs);

    always @* begin
        rword = 32'h00000000;
        rslot = slot_of({rofs[9:2], 2'b00});
        if (r_periph) begin
            rword = I_PERIPH_RDATA;
        end else if (rofs[15:10] == 6'h00) begin
            case ({rofs[9:2], 2'b00})
                `UHR_OFS_CAPLEN: rword = {`UHR_IFVER_VAL, 8'h00, `UHR_CAPLEN_VAL};
                `UHR_OFS_STRUCT: rword = `UHR_STRUCT_VAL;
                `UHR_OFS_CAPPAR: rword = `UHR_CAPPAR_VAL;
                `UHR_OFS_CHIPID: rword = `UHR_CHIPID_VAL;
                default: begin
                    if (rslot[6]) begin
                        rword = regs_q[rslot[5:0]];
                    end else begin
                        rword = 32'h00000000;
                    end
                end
            endcase
        end
    end

    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            waddr_q  <= 17'h00000;
            wd_q     <= 32'h00000000;
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            if (wr_act) begin
                waddr_q <= addr;
                wd_q    <= wd;
            end
        end
    end

    // Reset alone loads the listed values; after it only bus writes change them.
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            for (i = 0; i < `UHR_NUM_SLOTS; i = i + 1) begin
                regs_q[i] <= rst_of(i[5:0]);
            end
        end else if (word_wr && w_host && wslot[6]) begin
            regs_q[wslot[5:0]] <= word_wdata;
        end
    end

    // Read data and the bus drive come from flops.
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            data_q <= 32'h00000000;
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= ~rd_act;
            if (rd_go) begin
                data_q <= pair_rdata;
            end
        end
    end

    // Bank select and the peripheral hand-off.
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            bank_q   <= 2'b00;
            psel_q   <= 1'b0;
            pwr_q    <= 1'b0;
            pofs_q   <= 8'h00;
            pwdata_q <= 32'h00000000;
        end else begin
            psel_q <= cs & r_periph;
            pwr_q  <= word_wr & w_periph;
            if (rd_go) begin
                bank_q <= addr[17:16];
                pofs_q <= rofs[7:0];
            end else if (wr_go) begin
                bank_q <= waddr_q[17:16];
                pofs_q <= wofs[7:0];
            end
            if (word_wr & w_periph) begin
                pwdata_q <= word_wdata;
            end
        end
    end

    assign O_DATA         = data_q;
    assign O_DATA_OE_N    = oe_n_q;
    assign O_BANK         = bank_q;
    assign O_PERIPH_SEL   = psel_q;
    assign O_PERIPH_RD    = word_rd & r_periph;
    assign O_PERIPH_WR    = pwr_q;
    assign O_PERIPH_OFS   = pofs_q;
    assign O_PERIPH_WDATA = pwdata_q;
    assign O_HOST_CMD     = regs_q[0];
    assign O_HW_MODE      = regs_q[15];
endmodule

// ==== verilog/uhr_consts.vh ====
// Register offsets, reset values and capability constants of the host register bank.
`ifndef UHR_CONSTS_VH
`define UHR_CONSTS_VH
`define UHR_OFS_CAPLEN   10'h000
`define UHR_OFS_IFVER    10'h002
`define UHR_OFS_STRUCT   10'h004
`define UHR_OFS_CAPPAR   10'h008
`define UHR_OFS_HCMD     10'h020
`define UHR_OFS_HSTS     10'h024
`define UHR_OFS_HIEN     10'h028
`define UHR_OFS_FRIDX    10'h02C
`define UHR_OFS_CFGFLG   10'h060
`define UHR_OFS_PORT1    10'h064
`define UHR_OFS_ISODONE  10'h130
`define UHR_OFS_ISOSKIP  10'h134
`define UHR_OFS_ISOLAST  10'h138
`define UHR_OFS_INTDONE  10'h140
`define UHR_OFS_INTSKIP  10'h144
`define UHR_OFS_INTLAST  10'h148
`define UHR_OFS_ASYDONE  10'h150
`define UHR_OFS_ASYSKIP  10'h154
`define UHR_OFS_ASYLAST  10'h158
`define UHR_OFS_HWMODE   10'h300
`define UHR_OFS_CHIPID   10'h304
`define UHR_OFS_SCRATCH  10'h308
`define UHR_OFS_SWRST    10'h30C
`define UHR_OFS_IRQFLG   10'h310
`define UHR_OFS_IRQFEN   10'h314
`define UHR_OFS_ISOOR    10'h318
`define UHR_OFS_INTOR    10'h31C
`define UHR_OFS_ASYOR    10'h320
`define UHR_OFS_ISOAND   10'h324
`define UHR_OFS_INTAND   10'h328
`define UHR_OFS_ASYAND   10'h32C
`define UHR_OFS_DMACFG   10'h330
`define UHR_OFS_BUFSTS   10'h334
`define UHR_OFS_ASYTMO   10'h338
`define UHR_OFS_MEMSET   10'h33C
`define UHR_OFS_EDGECNT  10'h340
`define UHR_OFS_DMASTA   10'h344
`define UHR_OFS_PWRDN    10'h354
`define UHR_CAPLEN_VAL   8'h20
`define UHR_IFVER_VAL    16'h0100
`define UHR_STRUCT_VAL   32'h00000011
`define UHR_CAPPAR_VAL   32'h00000086
`define UHR_RST_ZERO     32'h00000000
`define UHR_RST_HCMD     32'h00080B00
`define UHR_RST_PORT1    32'h00002000
`define UHR_RST_SKIP     32'hFFFFFFFF
`define UHR_RST_HWMODE   32'h00000100
`define UHR_RST_EDGECNT  32'h0000000F
`define UHR_RST_PWRDN    32'h03E81BA0
// The identity value is arbitrary and names no real part.
`define UHR_CHIPID_VAL   32'h0000ABCD
`define UHR_NUM_SLOTS    33
`define UHR_PER_REGION   2'b10
`endif

// ==== verilog/uhr_pin_sync.v ====
// Two-stage synchroniser for the asynchronous bus pins.
module uhr_pin_sync #(
    parameter W = 1
) (
    input  wire         i_clk,
    input  wire         i_rst_n,
    input  wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= {W{1'b1}};
            sync_q <= {W{1'b1}};
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;
endmodule

// ==== verilog/uhr_half_pair.v ====
// Pairs two 16-bit half accesses into one 32-bit register read or write.
module uhr_half_pair (
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire        i_bus16,
    input  wire        i_rd_go,
    input  wire        i_wr_go,
    input  wire        i_hi,
    input  wire [31:0] i_wdata,
    input  wire [31:0] i_rword,
    output wire [31:0] o_rdata,
    output wire        o_word_rd,
    output wire        o_word_wr,
    output wire [31:0] o_word_wdata
);
    reg [15:0] lo_q;
    reg        lo_ok_q;
    reg [31:0] rlat_q;
    reg        rok_q;
    wire [15:0] hi_half;

    // A 32-bit bus moves whole words; a 16-bit bus writes the word on the upper half and reads it on the lower half.
    assign o_word_wr    = i_wr_go & (~i_bus16 | (i_hi & lo_ok_q));
    assign o_word_wdata = i_bus16 ? {i_wdata[15:0], lo_q} : i_wdata;
    assign o_word_rd    = i_rd_go & (~i_bus16 | ~i_hi | ~rok_q);
    assign hi_half      = rok_q ? rlat_q[31:16] : i_rword[31:16];
    assign o_rdata      = ~i_bus16 ? i_rword :
                          (i_hi ? {16'h0000, hi_half} : {16'h0000, i_rword[15:0]});

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lo_q    <= 16'h0000;
            lo_ok_q <= 1'b0;
            rlat_q  <= 32'h00000000;
            rok_q   <= 1'b0;
        end else begin
            if (i_wr_go & i_bus16) begin
                if (!i_hi) begin
                    lo_q    <= i_wdata[15:0];
                    lo_ok_q <= 1'b1;
                end else begin
                    lo_ok_q <= 1'b0;
                end
            end
            if (i_rd_go & i_bus16) begin
                if (!i_hi) begin
                    rlat_q <= i_rword;
                    rok_q  <= 1'b1;
                end else begin
                    rok_q  <= 1'b0;
                end
            end
        end
    end
endmodule

// ==== bench/uhr_top_monitor.sv ====
// Concurrent checks on the pins of the host register bank.
module uhr_monitor (
    input wire logic        I_CLK,
    input wire logic        I_RST_N,
    input wire logic        I_CS_N,
    input wire logic        I_RD_N,
    input wire logic        I_WR_N,
    input wire logic [17:1] I_ADDR,
    input wire logic        I_BUS16,
    input wire logic [31:0] O_DATA,
    input wire logic        O_DATA_OE_N,
    input wire logic [1:0]  O_BANK,
    input wire logic        O_PERIPH_SEL,
    input wire logic        O_PERIPH_RD,
    input wire logic        O_PERIPH_WR,
    input wire logic [31:0] O_HOST_CMD
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);
    property p_rd_drive;
        (!I_CS_N && !I_RD_N) [*6] |-> !O_DATA_OE_N;
    endproperty
    property p_rd_free;
        I_RD_N [*6] |-> O_DATA_OE_N;
    endproperty
    property p_prd_range;
        O_PERIPH_RD |-> !I_CS_N && I_ADDR[15:8] == 8'h02;
    endproperty
    property p_prd_pulse;
        O_PERIPH_RD |=> !O_PERIPH_RD;
    endproperty
    property p_pwr_late;
        O_PERIPH_WR |-> I_WR_N && $past(I_WR_N) ##1 !O_PERIPH_WR;
    endproperty
    // A write is taken only as its strobe closes, so the bank is checked after release.
    property p_bank;
        (!I_CS_N && $stable(I_ADDR)) [*7] ##1 I_CS_N [*4] |-> O_BANK == I_ADDR[17:16];
    endproperty
    property p_sel;
        (!I_CS_N && $stable(I_ADDR)) [*5] |-> O_PERIPH_SEL == (I_ADDR[15:8] == 8'h02);
    endproperty
    property p_rst_vals;
        $past(!I_RST_N) |-> O_HOST_CMD == 32'h00080B00 && O_DATA_OE_N;
    endproperty
    property p_half16;
        I_BUS16 [*8] ##0 !O_DATA_OE_N [*2] |-> O_DATA[31:16] == 16'h0000;
    endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("bus not driven in read");
    a_rd_free: assert property (p_rd_free) else $error("bus driven without read");
    a_prd_range: assert property (p_prd_range) else $error("peripheral read out of range");
    a_prd_pulse: assert property (p_prd_pulse) else $error("peripheral read too long");
    a_pwr_late: assert property (p_pwr_late) else $error("peripheral write early");
    a_bank: assert property (p_bank) else $error("bank select not taken");
    a_sel: assert property (p_sel) else $error("peripheral select wrong");
    a_rst_vals: assert property (p_rst_vals) else $error("reset value lost");
    a_half16: assert property (p_half16) else $error("upper half driven");
    c_prd: cover property (O_PERIPH_RD);
    c_pwr: cover property (O_PERIPH_WR);
    c_half: cover property (I_BUS16 && !O_DATA_OE_N);
endmodule

// ==== bench/uhr_host_model.sv ====
// Host processor model running asynchronous register cycles on the bus pins.
module uhr_host_model (
    input  wire logic        clk,
    input  wire logic [31:0] rdata,
    output logic             cs_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic [17:1]      addr,
    output logic [31:0]      wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // Select and strobes are driven from time zero on.
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 17'h00000;
        wdata = 32'h00000000;
    end
    // Strobe held eight cycles, then five idle cycles with the data lines driven to the inverse of the data.
    task automatic access(input logic wr, input logic [17:1] a, input logic [31:0] d,
                          output logic [31:0] q);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        cs_n = 1'b0;
        rd_n = wr;
        wr_n = !wr;
        repeat (8) @(posedge clk);
        q = rdata;
        #1;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        wdata = ~d;
        repeat (5) @(posedge clk);
    endtask
endmodule

// ==== bench/uhr_top_tb.sv ====
// Self-checking testbench of the host register bank with a reference model.
`include "uhr_consts.vh"
module uhr_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk;
    logic        rst_n;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic [17:1] addr;
    logic [31:0] wdata;
    logic        bus16;
    logic [31:0] prdata;
    logic [31:0] rdata;
    logic        oe_n;
    logic [1:0]  bank;
    logic        psel;
    logic        prd;
    logic        pwr;
    logic [7:0]  pofs;
    logic [31:0] pwd;
    logic [31:0] hcmd;
    logic [31:0] hwm;
    logic [31:0] pw_data;
    logic [31:0] got;
    logic [31:0] d;
    logic [31:0] seed;
    logic [31:0] mdl [int];
    int          ofs [$];
    int          un [6] = '{10'h00C, 10'h1FC, 10'h348, 10'h3FC, 16'h0400, 16'h7FFC};
    int          fail_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          prd_n = 0;
    int          pwr_n = 0;
    uhr_top DUT (
        .I_CLK          (clk),
        .I_RST_N        (rst_n),
        .I_CS_N         (cs_n),
        .I_RD_N         (rd_n),
        .I_WR_N         (wr_n),
        .I_ADDR         (addr),
        .I_DATA         (wdata),
        .I_BUS16        (bus16),
        .I_PERIPH_RDATA (prdata),
        .O_DATA         (rdata),
        .O_DATA_OE_N    (oe_n),
        .O_BANK         (bank),
        .O_PERIPH_SEL   (psel),
        .O_PERIPH_RD    (prd),
        .O_PERIPH_WR    (pwr),
        .O_PERIPH_OFS   (pofs),
        .O_PERIPH_WDATA (pwd),
        .O_HOST_CMD     (hcmd),
        .O_HW_MODE      (hwm)
    );
    uhr_host_model u_host (
        .clk   (clk),
        .rdata (rdata),
        .cs_n  (cs_n),
        .rd_n  (rd_n),
        .wr_n  (wr_n),
        .addr  (addr),
        .wdata (wdata)
    );
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (pwr === 1'b1) begin
            pwr_n <= pwr_n + 1;
            pw_data <= pwd;
        end
        if (prd === 1'b1) begin
            prd_n <= prd_n + 1;
        end
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    function automatic logic [31:0] nxt();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [31:0] exp_rd(input int o);
        if (o >= 16'h0400) return 32'h0;
        if (o[9:8] == 2'b10) return prdata;
        return mdl.exists(o) ? mdl[o] : 32'h0;
    endfunction
    task automatic init_model();
        foreach (ofs[i]) mdl[ofs[i]] = 32'h0;
        mdl[10'h000] = 32'h01000020;
        mdl[10'h004] = 32'h00000011;
        mdl[10'h008] = 32'h00000086;
        mdl[10'h020] = 32'h00080B00;
        mdl[10'h064] = 32'h00002000;
        mdl[10'h134] = 32'hFFFFFFFF;
        mdl[10'h144] = 32'hFFFFFFFF;
        mdl[10'h154] = 32'hFFFFFFFF;
        mdl[10'h300] = 32'h00000100;
        mdl[10'h304] = `UHR_CHIPID_VAL;
        mdl[10'h340] = 32'h0000000F;
        mdl[10'h354] = 32'h03E81BA0;
    endtask
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic acc(input logic wr, input int o, input logic [31:0] v);
        logic [1:0] b;
        void'(nxt());
        b = seed[1:0];
        u_host.access(wr, {b, o[15:1]}, v, got);
        chk_word({30'h0, bank}, {30'h0, b}, "bank");
    endtask
    task automatic rd(input int o, input logic [31:0] e);
        acc(1'b0, o, nxt());
        chk_word(got, e, "read");
    endtask
    task automatic wr(input int o, input logic [31:0] v);
        acc(1'b1, o, v);
        if (mdl.exists(o) && !(o inside {10'h000, 10'h004, 10'h008, 10'h304})) mdl[o] = v;
    endtask
    initial begin
        rst_n = 1'b0;
        bus16 = 1'b0;
        prdata = 32'h0;
        seed = 32'hF7E7CB12;
        ofs = '{10'h000, 10'h004, 10'h008, 10'h020, 10'h024, 10'h028, 10'h02C, 10'h060,
                10'h064, 10'h130, 10'h134, 10'h138, 10'h140, 10'h144, 10'h148, 10'h150,
                10'h154, 10'h158, 10'h354};
        for (int a = 10'h300; a <= 10'h344; a += 4) begin
            ofs.push_back(a);
        end
        init_model();
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk_word(hcmd, 32'h00080B00, "cmd out");
        chk_word(hwm, 32'h00000100, "mode out");
        foreach (ofs[i]) rd(ofs[i], exp_rd(ofs[i]));
        $display("test reset_values done");
        foreach (ofs[i]) wr(ofs[i], nxt());
        foreach (un[i]) wr(un[i], nxt());
        foreach (ofs[i]) rd(ofs[i], exp_rd(ofs[i]));
        foreach (un[i]) rd(un[i], 32'h0);
        chk_word(hcmd, mdl[10'h020], "cmd out");
        chk_word(hwm, mdl[10'h300], "mode out");
        $display("test write_readback done");
        #1;
        prdata = nxt();
        d = nxt();
        wr(10'h2A4, d);
        chk_word(pw_data, d, "periph wdata");
        chk_word({24'h0, pofs}, 32'h000000A4, "periph ofs");
        rd(10'h2A4, prdata);
        chk_word(32'(pwr_n + prd_n), 32'h2, "periph pulses");
        rd(10'h308, mdl[10'h308]);
        $display("test peripheral done");
        #1;
        bus16 = 1'b1;
        repeat (4) @(posedge clk);
        acc(1'b1, 10'h30A, nxt());
        d = mdl[10'h308];
        rd(10'h308, {16'h0, d[15:0]});
        rd(10'h30A, {16'h0, d[31:16]});
        d = nxt();
        acc(1'b1, 10'h308, d);
        acc(1'b1, 10'h30A, {d[15:0], d[31:16]});
        rd(10'h308, {16'h0, d[15:0]});
        rd(10'h30A, {16'h0, d[31:16]});
        rd(10'h000, 32'h00000020);
        rd(10'h002, 32'h00000100);
        $display("test half_word done");
        #1;
        bus16 = 1'b0;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk_word(hcmd, 32'h00080B00, "cmd in reset");
        chk_word({31'h0, oe_n}, 32'h1, "oe in reset");
        rst_n = 1'b1;
        init_model();
        foreach (ofs[i]) rd(ofs[i], exp_rd(ofs[i]));
        $display("test second_reset done");
        stop_test();
    end
endmodule
bind uhr_top uhr_monitor u_mon (
    .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CS_N(I_CS_N), .I_RD_N(I_RD_N),
    .I_WR_N(I_WR_N), .I_ADDR(I_ADDR), .I_BUS16(I_BUS16), .O_DATA(O_DATA),
    .O_DATA_OE_N(O_DATA_OE_N), .O_BANK(O_BANK), .O_PERIPH_SEL(O_PERIPH_SEL),
    .O_PERIPH_RD(O_PERIPH_RD), .O_PERIPH_WR(O_PERIPH_WR), .O_HOST_CMD(O_HOST_CMD)
);
